// ---- fan_supervisor_params.svh ----
// Constants for the fan drive fault supervisor: timing figures and levels.
`ifndef FAN_SUPERVISOR_PARAMS_SVH
`define FAN_SUPERVISOR_PARAMS_SVH

// Clock rate in hertz.
`define CLK_HZ 20000000
// Figures in their own units.
`define NOTIFY_DELAY_S 30
`define QUIESCENT_DELAY_MS 600
`define WAKE_DELAY_MS 500
`define RETRY_FIRST_S 5
`define RETRY_STEP_S 5
`define RETRY_MAX_S 25
// Ramp times in tenths of a second (typical figures).
`define RAMP_UP_DS 109
`define RAMP_DOWN_DS 151
// Supply window in tenths of a volt.
`define SUPPLY_MIN_DV 160
`define SUPPLY_MAX_DV 320
// Cycle counts derived from the figures.
`define NOTIFY_CYCLES (`NOTIFY_DELAY_S * `CLK_HZ)
`define QUIESCENT_CYCLES ((`QUIESCENT_DELAY_MS * (`CLK_HZ / 1000)) + 1)
`define WAKE_CYCLES (`WAKE_DELAY_MS * (`CLK_HZ / 1000))
`define RETRY_FIRST_CYCLES (`RETRY_FIRST_S * `CLK_HZ)
`define RETRY_STEP_CYCLES (`RETRY_STEP_S * `CLK_HZ)
`define RETRY_MAX_CYCLES (`RETRY_MAX_S * `CLK_HZ)
`define RAMP_UP_CYCLES ((`RAMP_UP_DS * `CLK_HZ) / 10)
`define RAMP_DOWN_CYCLES ((`RAMP_DOWN_DS * `CLK_HZ) / 10)
// Duty width and full-scale speed value.
`define DUTY_W 8
`define SPEED_MAX 8'hff

`endif

// ---- fan_supervisor_pkg.sv ----
// Types shared by the fan drive fault supervisor.
package fan_supervisor_pkg;

  // Drive modes, one-hot.
  typedef enum logic [3:0] {
    mode_quiescent = 4'b0001,
    mode_active = 4'b0010,
    mode_run = 4'b0100,
    mode_failure = 4'b1000
  } mode_type;

  // Fault inputs from the measurement and power stages.
  typedef struct packed {
    logic over_current;
    logic blocked;
    logic overheated;
    logic overloaded;
    logic volt_meas_defect;
    logic curr_meas_defect;
    logic temp_meas_defect;
    logic rotor_meas_defect;
    logic gate_driver_fail;
  } fault_in_type;

  // Decoded speed command.
  typedef struct packed {
    logic valid;
    logic run;
    logic reverse;
    logic [7:0] speed;
  } command_type;

  // Drive outputs towards the power stage.
  typedef struct packed {
    logic enable;
    logic reverse;
    logic [7:0] speed;
  } drive_out_type;

endpackage : fan_supervisor_pkg

// ---- fan_drive_fault_supervisor.sv ----
// Mode, fault, notification and ramp control of a brushless fan drive.
// What this block does
// - Stop motor when supply leaves operating range.
// - Supply stops never raise fault feedback.
// - Over-current switches drive off into failure.
// - Measurement or gate-driver defects enter failure.
// - Feedback low in quiescent, active, run.
// - Feedback high in failure once the notify delay has run.
// - Feedback returns low when failure clears.
// - Feedback raised no sooner than thirty seconds.
// - Recovery attempted only under valid run request.
// - Leave failure at once when cause ends.
// - Duty is positive logic, high means full.
// - From standstill start in requested direction.
// - Reversal: coast to zero, then restart.
// - Forward ramp up takes about 10.9 s.
// - Ramp down takes about 15.1 s.
// - Backward ramp up takes about 10.9 s.
// - Quiescent after 600 ms at zero duty.
// - Blocked retries 5 s, growing to 25 s.
// - Activation level wakes within 500 ms.
`timescale 1ns/1ps
`default_nettype none
`include "fan_supervisor_params.svh"

module fan_drive_fault_supervisor #(
  parameter int unsigned NOTIFY_CYCLES = `NOTIFY_CYCLES,
  parameter int unsigned QUIESCENT_CYCLES = `QUIESCENT_CYCLES,
  parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES,
  parameter int unsigned RETRY_FIRST_CYCLES = `RETRY_FIRST_CYCLES,
  parameter int unsigned RETRY_STEP_CYCLES = `RETRY_STEP_CYCLES,
  parameter int unsigned RETRY_MAX_CYCLES = `RETRY_MAX_CYCLES,
  parameter int unsigned RAMP_UP_CYCLES = `RAMP_UP_CYCLES,
  parameter int unsigned RAMP_DOWN_CYCLES = `RAMP_DOWN_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Speed command input, already decoded to duty and activation level.
  input wire logic [7:0] command_duty,
  input wire logic command_valid,
  input wire logic command_active_level,
  // Supply voltage in tenths of a volt.
  input wire logic [9:0] supply_dv,
  // Fault inputs.
  input wire fan_supervisor_pkg::fault_in_type faults,
  // Rotor standstill indication.
  input wire logic rotor_stopped,
  // Drive outputs.
  output logic fault_feedback_output,
  output fan_supervisor_pkg::drive_out_type drive,
  output fan_supervisor_pkg::mode_type mode
);

  // ==========================================================================
  // Usage notes
  // ==========================================================================

  // The command input arrives already measured: a front end outside this
  // block turns the line into a duty byte, a validity flag and a flag for
  // the activation level, so no pulse timing is handled here.
  // Reset leaves the drive in the active mode rather than quiescent, so a
  // host that keeps the line at zero duty sends it to sleep after the
  // quiescent delay, just as on a cold start.
  // Only the blocked rotor is retried on a timer; every other failure waits
  // for its cause to go, and the failure mode is then left on the next edge.
  // A blocked rotor that stalls again after being notified raises its feedback at once on
  // re-entering failure, because the notified flag is only cleared once the cause has gone.
  // Supply excursions only hold the drive in the active mode; the speed set
  // point is kept, so the ramp resumes from where it stopped once the supply
  // is back inside its window.
  // The ramp divides the full-scale time into 255 equal steps and drops the
  // remainder, so a ramp may end up to 254 clock cycles early; at the real clock
  // rate that is far below the allowed spread.
  // Every timer is 32 bits wide; the longest delay at 20 MHz needs about
  // thirty bits, which leaves room for a faster clock than the nominal one.

  // ==========================================================================
  // Command decoding
  // ==========================================================================

  // Reverse band sits around 23 percent duty; run starts above the low band.
  localparam logic [7:0] REV_LO = 8'h32;
  localparam logic [7:0] REV_HI = 8'h44;
  localparam logic [7:0] RUN_MIN = 8'h4d;
  localparam logic [7:0] IDLE_MAX = 8'h0d;

  // Classify a duty into run and direction; shared by the state logic.
  function automatic fan_supervisor_pkg::command_type decode_cmd(
    input logic [7:0] duty,
    input logic valid
  );
    fan_supervisor_pkg::command_type c;
    c.valid = valid;
    c.reverse = (duty >= REV_LO) && (duty <= REV_HI);
    c.run = valid && (c.reverse || (duty >= RUN_MIN));
    c.speed = c.reverse ? `SPEED_MAX : duty;
    return c;
  endfunction : decode_cmd

  // ==========================================================================
  // State
  // ==========================================================================

  typedef struct packed {
    fan_supervisor_pkg::mode_type mode;
    logic [31:0] notify_count;
    logic [31:0] idle_count;
    logic [31:0] wake_count;
    logic [31:0] retry_count;
    logic [31:0] retry_limit;
    logic [31:0] ramp_count;
    logic [7:0] speed;
    logic reverse;
    logic coasting;
    logic notified;
    logic fault_out;
  } state_type;

  state_type state;
  state_type next_state;

  fan_supervisor_pkg::command_type cmd;
  logic supply_ok;
  logic hard_fault;
  logic blocked_fault;
  logic any_fault;
  logic [31:0] ramp_period;
  logic [31:0] grown_limit;

  assign cmd = decode_cmd(command_duty, command_valid);
  assign supply_ok = (supply_dv >= 10'(`SUPPLY_MIN_DV)) &&
                     (supply_dv <= 10'(`SUPPLY_MAX_DV));
  // Over-current and internal defects all count as drive failures.
  assign hard_fault = faults.over_current | faults.volt_meas_defect |
                      faults.curr_meas_defect | faults.temp_meas_defect |
                      faults.rotor_meas_defect | faults.gate_driver_fail |
                      faults.overheated | faults.overloaded;
  assign blocked_fault = faults.blocked;
  assign any_fault = hard_fault | blocked_fault;
  // Per-step ramp period: full scale over the whole ramp time.
  assign ramp_period = (drive.speed < cmd.speed) ?
                       32'(RAMP_UP_CYCLES / 255) :
                       32'(RAMP_DOWN_CYCLES / 255);
  assign grown_limit = state.retry_limit + 32'(RETRY_STEP_CYCLES);

  // ==========================================================================
  // Next state
  // ==========================================================================

  // Mode sequencing, delay counting and speed ramp in one pass.
  always_comb
  begin
    next_state = state;
    case (state.mode)
      fan_supervisor_pkg::mode_quiescent:
      begin
        next_state.speed = 8'h00;
        // Wake once the activation level has been seen long enough.
        if (command_active_level)
        begin
          next_state.wake_count = state.wake_count + 32'h1;
          if (state.wake_count >= 32'(WAKE_CYCLES - 1))
          begin
            next_state.mode = fan_supervisor_pkg::mode_active;
            next_state.wake_count = 32'h0;
          end
        end
        else
        begin
          next_state.wake_count = 32'h0;
        end
      end
      fan_supervisor_pkg::mode_active,
      fan_supervisor_pkg::mode_run:
      begin
        // Idle time counts only while the activation level is low and the duty is at most IDLE_MAX.
        if (!command_active_level && command_duty <= IDLE_MAX)
        begin
          next_state.idle_count = state.idle_count + 32'h1;
          if (state.idle_count >= 32'(QUIESCENT_CYCLES - 1))
          begin
            next_state.mode = fan_supervisor_pkg::mode_quiescent;
            next_state.idle_count = 32'h0;
          end
        end
        else
        begin
          next_state.idle_count = 32'h0;
        end
        if (any_fault)
        begin
          next_state.mode = fan_supervisor_pkg::mode_failure;
          next_state.speed = 8'h00;
          next_state.notify_count = 32'h0;
          next_state.retry_count = 32'h0;
          next_state.retry_limit = 32'(RETRY_FIRST_CYCLES);
        end
        else if (state.mode == fan_supervisor_pkg::mode_active)
        begin
          if (cmd.run && supply_ok)
          begin
            next_state.mode = fan_supervisor_pkg::mode_run;
          end
        end
        else if (!cmd.run || !supply_ok)
        begin
          // Supply excursions stop the motor without a failure.
          next_state.mode = fan_supervisor_pkg::mode_active;
        end
      end
      fan_supervisor_pkg::mode_failure:
      begin
        next_state.speed = 8'h00;
        next_state.notify_count = state.notify_count + 32'h1;
        if (state.notify_count >= 32'(NOTIFY_CYCLES - 1))
        begin
          next_state.notified = 1'b1;
          next_state.notify_count = state.notify_count;
        end
        if (!any_fault)
        begin
          // Cause gone: leave immediately and drop the feedback.
          next_state.mode = fan_supervisor_pkg::mode_active;
          next_state.notified = 1'b0;
          next_state.notify_count = 32'h0;
          next_state.retry_count = 32'h0;
        end
        else if (blocked_fault && !hard_fault && cmd.run && supply_ok)
        begin
          // Blocked rotor: spaced restart attempts under a run request.
          next_state.retry_count = state.retry_count + 32'h1;
          if (state.retry_count >= state.retry_limit - 32'h1)
          begin
            next_state.retry_count = 32'h0;
            next_state.mode = fan_supervisor_pkg::mode_run;
            next_state.retry_limit =
              (grown_limit > 32'(RETRY_MAX_CYCLES)) ?
              32'(RETRY_MAX_CYCLES) : grown_limit;
          end
        end
        else
        begin
          next_state.retry_count = 32'h0;
        end
      end
      default:
      begin
        next_state.mode = fan_supervisor_pkg::mode_active;
      end
    endcase

    // Keep the grown retry spacing while a blocked fault recurs in run.
    if (state.mode == fan_supervisor_pkg::mode_run && blocked_fault)
    begin
      next_state.retry_limit = state.retry_limit;
    end

    // Direction change waits for the rotor to coast to standstill.
    if (state.mode == fan_supervisor_pkg::mode_run)
    begin
      if (cmd.reverse != state.reverse)
      begin
        if (rotor_stopped && state.speed == 8'h00)
        begin
          next_state.reverse = cmd.reverse;
          next_state.coasting = 1'b0;
        end
        else
        begin
          next_state.coasting = 1'b1;
          next_state.speed = 8'h00;
        end
      end
      else
      begin
        next_state.coasting = 1'b0;
        next_state.ramp_count = state.ramp_count + 32'h1;
        // A step is due once the count has covered one whole period;
        // comparing the incremented count keeps the period exact.
        if (state.ramp_count + 32'h1 >= ramp_period)
        begin
          next_state.ramp_count = 32'h0;
          if (state.speed < cmd.speed)
          begin
            next_state.speed = state.speed + 8'h01;
          end
          else if (state.speed > cmd.speed)
          begin
            next_state.speed = state.speed - 8'h01;
          end
        end
      end
    end
    else
    begin
      next_state.ramp_count = 32'h0;
      next_state.coasting = 1'b0;
    end

    // Feedback only in failure, after the delay, and never for supply.
    next_state.fault_out = (next_state.mode == fan_supervisor_pkg::mode_failure)
                           && next_state.notified;
  end

  // ==========================================================================
  // State register
  // ==========================================================================

  // Synchronous reset puts the drive in the active mode with no fault shown.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state <= '0;
      state.mode <= fan_supervisor_pkg::mode_active;
      state.retry_limit <= 32'(RETRY_FIRST_CYCLES);
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================

  assign fault_feedback_output = state.fault_out;
  assign mode = state.mode;
  // Drive is also held off while the requested direction differs from the
  // latched one, so no edge ever pushes the rotor the wrong way.
  assign drive.enable = (state.mode == fan_supervisor_pkg::mode_run) &&
                        !state.coasting && supply_ok &&
                        (cmd.reverse == state.reverse);
  assign drive.reverse = state.reverse;
  assign drive.speed = state.speed;

endmodule : fan_drive_fault_supervisor
`default_nettype wire

// ---- fan_supervisor_checker.sv ----
// Port assertions of the fan drive fault supervisor.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module fan_supervisor_checker #(
  parameter int unsigned NOTIFY_CYCLES = 20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Watched ports.
  input wire logic [9:0] supply_dv,
  input wire fan_supervisor_pkg::fault_in_type faults,
  input wire logic rotor_stopped,
  input wire logic fault_feedback_output,
  input wire fan_supervisor_pkg::drive_out_type drive,
  input wire fan_supervisor_pkg::mode_type mode
);
  logic fail;
  logic up;
  logic bad_supply;
  int unsigned fail_cycles;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Mode decodes and the supply window.
  assign fail = (mode == fan_supervisor_pkg::mode_failure);
  assign up = (mode == fan_supervisor_pkg::mode_active) ||
    (mode == fan_supervisor_pkg::mode_run);
  assign bad_supply = (supply_dv < 10'h0a0) || (supply_dv > 10'h140);
  // Edges spent in failure; saturates so a long stall cannot wrap.
  always_ff @(posedge clk)
  begin
    if (!fail)
      fail_cycles <= 0;
    else if (fail_cycles < 1000)
      fail_cycles <= fail_cycles + 1;
  end
  a_fb_low: assert property (!fail |-> !fault_feedback_output)
    else $error("feedback high outside failure");
  a_fb_late: assert property (fault_feedback_output |->
    fail && fail_cycles >= NOTIFY_CYCLES)
    else $error("feedback raised too early");
  a_fb_on: assert property (fail && fail_cycles > NOTIFY_CYCLES |->
    fault_feedback_output)
    else $error("feedback missing in failure");
  a_oc_fail: assert property (up && faults.over_current |=> fail)
    else $error("over current did not stop drive");
  a_int_fail: assert property (up && (|faults[4:0]) |=> fail)
    else $error("internal defect did not stop drive");
  a_leave_fail: assert property (fail && faults == '0 |=>
    mode == fan_supervisor_pkg::mode_active && !fault_feedback_output)
    else $error("failure kept after cause ended");
  a_supply_stop: assert property (bad_supply |-> !drive.enable)
    else $error("drive enabled outside supply window");
  a_supply_quiet: assert property (bad_supply && faults == '0 && !fail
    |=> !fail)
    else $error("supply stop treated as failure");
  a_rev_still: assert property ($changed(drive.reverse) |->
    $past(rotor_stopped))
    else $error("direction changed while turning");
  a_fail_off: assert property (fail |-> !drive.enable)
    else $error("drive enabled in failure");
endmodule : fan_supervisor_checker
bind fan_drive_fault_supervisor fan_supervisor_checker #(
  .NOTIFY_CYCLES(NOTIFY_CYCLES)
) u_checker (.clk(clk), .rst_b(rst_b), .supply_dv(supply_dv),
  .faults(faults), .rotor_stopped(rotor_stopped),
  .fault_feedback_output(fault_feedback_output), .drive(drive), .mode(mode));
`default_nettype wire

// ---- host_control_unit_model.sv ----
// Model of the host control unit driving the speed command line.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host model
module host_control_unit_model (
  // Clock.
  input wire logic clk,
  // Requests from the bench.
  input wire logic [7:0] req_duty,
  input wire logic req_valid,
  // Decoded command line towards the drive.
  output logic [7:0] command_duty = 8'h00,
  output logic command_valid = 1'b0,
  output logic command_active_level = 1'b0
);
  // The line is driven low at zero duty, never left to float upwards.
  always @(negedge clk)
  begin
    command_duty <= req_duty;
    command_valid <= req_valid;
    command_active_level <= (req_duty != 8'h00);
  end
endmodule : host_control_unit_model
`default_nettype wire

// ---- test_fan_drive_fault_supervisor.sv ----
// Self-checking bench of the fan drive fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module test_fan_drive_fault_supervisor;
  // ==========================================================
  // Setup: short counts keep the run brief.
  localparam int NOTIFY = 20;
  localparam int RFIRST = 8;
  // Ramp counts are whole multiples of 255, so every step is equally long.
  localparam int RUP = 765;
  localparam int RDN = 1020;
  localparam fan_supervisor_pkg::mode_type m_act =
    fan_supervisor_pkg::mode_active;
  localparam fan_supervisor_pkg::mode_type m_run = fan_supervisor_pkg::mode_run;
  localparam fan_supervisor_pkg::mode_type m_fail =
    fan_supervisor_pkg::mode_failure;
  localparam fan_supervisor_pkg::mode_type m_qui =
    fan_supervisor_pkg::mode_quiescent;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] req_duty = 8'h00;
  logic req_valid = 1'b1;
  logic [7:0] command_duty;
  logic command_valid;
  logic command_active_level;
  logic [9:0] supply_dv = 10'h0f0;
  fan_supervisor_pkg::fault_in_type faults = '0;
  logic rotor_stopped = 1'b1;
  logic fault_feedback_output;
  fan_supervisor_pkg::drive_out_type drive;
  fan_supervisor_pkg::mode_type mode;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'ha2361297;
  host_control_unit_model u_host (.clk(clk), .req_duty(req_duty),
    .req_valid(req_valid), .command_duty(command_duty),
    .command_valid(command_valid), .command_active_level(command_active_level));
  fan_drive_fault_supervisor #(.NOTIFY_CYCLES(NOTIFY), .QUIESCENT_CYCLES(12),
    .WAKE_CYCLES(10), .RETRY_FIRST_CYCLES(RFIRST), .RETRY_STEP_CYCLES(4),
    .RETRY_MAX_CYCLES(16), .RAMP_UP_CYCLES(RUP), .RAMP_DOWN_CYCLES(RDN))
  u_dut (.clk(clk), .rst_b(rst_b), .command_duty(command_duty),
    .command_valid(command_valid), .command_active_level(command_active_level),
    .supply_dv(supply_dv), .faults(faults), .rotor_stopped(rotor_stopped),
    .fault_feedback_output(fault_feedback_output), .drive(drive), .mode(mode));
  // Clock of 50 ns; the timeout cuts a hang short.
  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_mode(input fan_supervisor_pkg::mode_type m,
    input int lim, output int n);
    n = 0;
    while (mode !== m && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_mode
  task automatic run_up(input logic [7:0] d);
    int n;
    req_duty = d;
    wait_mode(m_run, 40, n);
    check(8'(mode), 8'(m_run), "run mode");
  endtask : run_up
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // Scenarios
  initial
  begin
    int n;
    int k;
    int i;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    check(8'(mode), 8'(m_act), "reset mode");
    check(8'(fault_feedback_output), 8'h00, "reset fb");
    run_up(8'hff);
    rotor_stopped = 1'b0;
    n = 0;
    while (drive.speed !== 8'hff && n < 2 * RUP)
    begin
      @(negedge clk);
      n++;
    end
    check(drive.speed, 8'hff, "full speed");
    check(8'(n >= RUP * 104 / 109 && n <= RUP * 118 / 109), 8'h01,
      "ramp up time");
    check(8'(drive.reverse), 8'h00, "forward");
    check(8'(drive.enable), 8'h01, "driving");
    // Partial slow-down: 178 of the 255 steps of a full-scale ramp.
    req_duty = 8'h4d;
    n = 0;
    while (drive.speed !== 8'h4d && n < 2 * RDN)
    begin
      @(negedge clk);
      n++;
    end
    check(drive.speed, 8'h4d, "slowed");
    k = RDN * 178 / 255;
    check(8'(n >= k - 4 && n <= k * 165 / 151 + 4), 8'h01,
      "ramp down time");
    req_duty = 8'h3b;
    repeat (20) @(negedge clk);
    check(8'(drive.enable), 8'h00, "coasting");
    check(8'(drive.reverse), 8'h00, "no flip while turning");
    rotor_stopped = 1'b1;
    repeat (10) if (drive.reverse !== 1'b1) @(negedge clk);
    check(8'(drive.reverse), 8'h01, "reversed");
    done("ramp and reversal");
    req_duty = 8'h00;
    wait_mode(m_qui, 960, n);
    check(8'(mode), 8'(m_qui), "quiescent");
    check(8'(n >= 12), 8'h01, "idle time");
    req_duty = 8'h08;
    wait_mode(m_act, 20, n);
    check(8'(mode), 8'(m_act), "woken");
    done("idle and wake");
    // Every fault source except blocked, which retries on its own.
    for (i = 0; i < 9; i++)
    begin
      if (i == 7)
        continue;
      run_up(8'h4d + 8'($unsigned($random(seed)) % 179));
      faults = fan_supervisor_pkg::fault_in_type'(9'h001 << i);
      repeat (2) @(negedge clk);
      check(8'(mode), 8'(m_fail), "failure");
      check(8'(drive.enable), 8'h00, "drive off");
      repeat (NOTIFY) @(negedge clk);
      check(8'(fault_feedback_output), 8'h01, "fb up");
      faults = '0;
      @(negedge clk);
      check(8'(mode), 8'(m_act), "left failure");
      check(8'(fault_feedback_output), 8'h00, "fb down");
    end
    done("faults");
    for (i = 0; i < 2; i++)
    begin
      run_up(8'hc0);
      k = $unsigned($random(seed)) % 160;
      supply_dv = (i == 1) ? 10'(321 + k) : 10'(k);
      repeat (2) @(negedge clk);
      check(8'(drive.enable), 8'h00, "supply stop");
      repeat (NOTIFY + 5) @(negedge clk);
      check(8'(mode == m_fail), 8'h00, "no failure");
      check(8'(fault_feedback_output), 8'h00, "fb quiet");
      supply_dv = 10'(160 + k);
    end
    done("supply window");
    run_up(8'hc0);
    faults.blocked = 1'b1;
    wait_mode(m_fail, 5, n);
    wait_mode(m_run, RFIRST + 4, n);
    check(8'(n >= RFIRST - 2 && n <= RFIRST + 2), 8'h01, "first retry");
    wait_mode(m_fail, 5, k);
    wait_mode(m_run, 40, k);
    check(8'(k > n), 8'h01, "retry spacing grows");
    req_duty = 8'h00;
    repeat (2) @(negedge clk);
    wait_mode(m_fail, 5, k);
    wait_mode(m_run, 40, k);
    check(8'(mode == m_run), 8'h00, "no retry when idle");
    req_duty = 8'hc0;
    req_valid = 1'b0;
    wait_mode(m_run, 40, k);
    check(8'(mode == m_run), 8'h00, "no retry when invalid");
    faults = '0;
    done("blocked retry");
    print_verdict();
  end
endmodule : test_fan_drive_fault_supervisor
`default_nettype wire
